// ==== ssr_bus_ctrl.sv ====
// ----------
// Bus controller model: answers service requests by serial poll.
// ----------
module ssr_bus_ctrl #(
   parameter int LAT = 3
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Host program control.
   input wire logic en,
   output int poll_cnt_r,
   // Device side.
   input wire logic rqs_r,
   output logic spoll
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_r;
   // A slow host: poll LAT+1 cycles after the request line rises; spoll is one cycle.
   // The poll is not repeated while the old request is still seen.
   always_ff @(posedge clk) begin
      if (rst) begin
         spoll <= 1'b0;
         wait_r <= 4'h0;
         poll_cnt_r <= 0;
      end else begin
         spoll <= 1'b0;
         if (spoll) poll_cnt_r <= poll_cnt_r + 1;
         if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
            if (wait_r == 4'h1) spoll <= 1'b1;
         end else if (en && rqs_r && !spoll) begin
            wait_r <= 4'(LAT);
         end
      end
   end
endmodule

// ==== ssr_map.svh ====
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
// ---------------------------------------------------------------
// Register offsets (word index on the plain register port).
// ---------------------------------------------------------------
`define SSR_OFS_STB 4'h0
`define SSR_OFS_SRE 4'h1
`define SSR_OFS_ESR 4'h2
`define SSR_OFS_ESE 4'h3
`define SSR_OFS_QCOND 4'h4
`define SSR_OFS_QEVT 4'h5
`define SSR_OFS_QENA 4'h6
`define SSR_OFS_ERR 4'h7
`define SSR_OFS_PSC 4'h8
`define SSR_OFS_CMD 4'h9
// ---------------------------------------------------------------
// Status byte and standard event bit positions.
// ---------------------------------------------------------------
`define SSR_STB_QUES 3
`define SSR_STB_MAV 4
`define SSR_STB_ESB 5
`define SSR_STB_RQS 6
`define SSR_ESR_OPC 0
`define SSR_ESR_QYE 2
`define SSR_ESR_DDE 3
`define SSR_ESR_EXE 4
`define SSR_ESR_CME 5
`define SSR_ESR_PON 7
// ---------------------------------------------------------------
// Command word bits, error codes, depths.
// ---------------------------------------------------------------
`define SSR_CMD_CLS 0
`define SSR_CMD_OPC 1
`define SSR_CMD_OPCQ 2
`define SSR_CMD_STBQ 3
`define SSR_CMD_WAI 4
`define SSR_ERR_NONE 16'h0000
`define SSR_ERR_OVF 16'hfea2
`define SSR_OPCQ_ANS 8'h01
`define SSR_ERR_DEPTH 20
`define SSR_OUT_DEPTH 4
`endif

// ==== ssr_pkg.sv ====
package ssr_pkg;
   // Error report from the rest of the instrument.
   typedef struct packed {
      logic valid;
      logic [15:0] code;
   } ssr_err_t;
   // Standard event pulses from parser and self test.
   typedef struct packed {
      logic qye;
      logic dde;
      logic exe;
      logic cme;
   } ssr_std_ev_t;
   // Response byte placed into the output buffer.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ssr_resp_t;
   // Command sequencer states.
   typedef enum logic {SSR_IDLE, SSR_HOLD} ssr_exec_t;
endpackage

// ==== ssr_status_unit.sv ====
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "ssr_map.svh"

// Overview of operation
// - Enabled summary sets request service, raises request.
// - Request cleared by poll or causing register read.
// - Serial poll returns byte, clears only request.
// - Status query returns same byte, clears nothing.
// - Status query executes in the same cycle as earlier commands still held.
// - Message available while output buffer holds data.
// - Completion command sets event bit 0.
// - Completion query places 1 in output buffer.
// - Twenty entry first-in first-out error queue.
// - Overflow replaces newest with -350, stops storing.
// - Empty queue read returns zero.
// - Power loss, clear-status empty queue; reset not.
// - Error pending while non-empty; beep per error.
// - Unlatched condition: 0 off, 1 CC, 2 CV, 3 fail.
// - Questionable events latch; read clears them.
// - Questionable enable selects summary, reads back.
// - Clear-status clears events and status summary.
// - Standard event enable selects summary, reads back.
// - Power-on clear setting governs SRE and ESE masks at power-up.
// - Wait blocks later commands until operations finish.
// - Output overload stops command processing.
// - Status byte bits 3, 4, 5, 6 layout.
// - Standard event bits 1,4,8,16,32,128.
// - Standard event read clears it and bit 5.
module ssr_status_unit
   import ssr_pkg::*;
#(
   parameter int ERR_DEPTH = `SSR_ERR_DEPTH,
   parameter int OUT_DEPTH = `SSR_OUT_DEPTH
) (
   // Clock and power-on reset.
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata_r,
   // Non-volatile settings restored at power-up.
   input wire logic psc_saved,
   input wire logic [7:0] sre_saved,
   input wire logic [7:0] ese_saved,
   // Instrument state and events.
   input wire logic ops_pending,
   input wire logic [1:0] qcond,
   input wire logic [15:0] ques_set,
   input wire ssr_std_ev_t std_ev,
   input wire ssr_err_t err_in,
   // Bus interface side.
   input wire logic spoll,
   input wire logic dev_clear,
   input wire logic msg_push,
   input wire logic msg_read,
   output logic [7:0] spoll_byte_r,
   output logic rqs_r,
   output ssr_resp_t resp_r,
   // Front panel and flow.
   output logic err_pending_r,
   output logic beep_r,
   output logic halted_r
);
   localparam int PW = $clog2(ERR_DEPTH);
   localparam int CW = $clog2(ERR_DEPTH + 1);
   localparam int OW = $clog2(OUT_DEPTH + 1);

   // ---------------------------------------------------------------
   // Storage.
   // ---------------------------------------------------------------
   logic [7:0] sre_r, ese_r, esr_r, stb;
   logic [15:0] qevt_r, qena_r;
   logic psc_r;
   logic [4:0] cmd_r;
   logic [2:0] cause_r;
   logic srv, srv_d_r, srv_rise, ques_sum, esb_sum, mav;
   logic [OW-1:0] msgs_r;
   logic [15:0] err_mem [ERR_DEPTH];
   logic [PW-1:0] wr_ptr_r, rd_ptr_r;
   logic [CW-1:0] err_cnt_r;
   logic err_ovf_r;
   ssr_exec_t st_r;
   logic exec, do_cls, do_opc, do_opcq, do_stbq, push_resp;
   logic wr_reg, rd_esr, rd_qevt, rd_err, err_push, err_pop;

   // Pointer wrap, shared by both queue pointers.
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      return (p == PW'(ERR_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // ---------------------------------------------------------------
   // Strobe decode.
   // ---------------------------------------------------------------
   // Register write qualifier and side-effect reads.
   assign wr_reg = wr;
   assign rd_esr = rd && (addr == `SSR_OFS_ESR);
   assign rd_qevt = rd && (addr == `SSR_OFS_QEVT);
   assign rd_err = rd && (addr == `SSR_OFS_ERR);

   // ---------------------------------------------------------------
   // Command sequencer.
   // ---------------------------------------------------------------
   // Commands wait for earlier operations; the wait command needs
   // no extra state because every command already waits.
   assign exec = (st_r == SSR_HOLD) && !ops_pending && !halted_r;
   assign do_cls = exec && cmd_r[`SSR_CMD_CLS];
   assign do_opc = exec && cmd_r[`SSR_CMD_OPC];
   assign do_opcq = exec && cmd_r[`SSR_CMD_OPCQ];
   assign do_stbq = exec && cmd_r[`SSR_CMD_STBQ];

   // Command word latch; a write in the executing cycle is kept.
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_r <= '0;
         st_r <= SSR_IDLE;
      end else begin
         case (st_r)
            SSR_IDLE: begin
               if (wr_reg && addr == `SSR_OFS_CMD && wdata[4:0] != '0) begin
                  cmd_r <= wdata[4:0];
                  st_r <= SSR_HOLD;
               end
            end
            SSR_HOLD: begin
               if (wr_reg && addr == `SSR_OFS_CMD) begin
                  cmd_r <= exec ? wdata[4:0] : (cmd_r | wdata[4:0]);
                  if (exec && wdata[4:0] == '0) begin
                     st_r <= SSR_IDLE;
                  end
               end else if (exec) begin
                  cmd_r <= '0;
                  st_r <= SSR_IDLE;
               end
            end
            default: st_r <= SSR_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output buffer accounting.
   // ---------------------------------------------------------------
   assign push_resp = do_opcq || do_stbq;

   // Counts queued messages; an overload halts commands until a
   // device clear empties the buffer.
   always_ff @(posedge clk) begin
      if (rst || dev_clear) begin
         msgs_r <= '0;
         halted_r <= 1'b0;
      end else begin
         if ((push_resp || msg_push) && msgs_r == OW'(OUT_DEPTH)) begin
            halted_r <= 1'b1;
         end else if ((push_resp || msg_push) && !msg_read) begin
            msgs_r <= msgs_r + 1'b1;
         end else if (!(push_resp || msg_push) && msg_read && msgs_r != '0) begin
            msgs_r <= msgs_r - 1'b1;
         end
      end
   end

   // Response byte to the output buffer.
   always_ff @(posedge clk) begin
      if (rst) begin
         resp_r <= '0;
      end else begin
         resp_r.valid <= push_resp;
         if (do_opcq) begin
            resp_r.data <= `SSR_OPCQ_ANS;
         end else if (do_stbq) begin
            resp_r.data <= stb;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status byte and request service.
   // ---------------------------------------------------------------
   // Summaries are not latched; they follow their event registers.
   always_comb begin
      ques_sum = |(qevt_r & qena_r);
      esb_sum = |(esr_r & ese_r);
      mav = (msgs_r != '0);
      stb = 8'h00;
      stb[`SSR_STB_QUES] = ques_sum;
      stb[`SSR_STB_MAV] = mav;
      stb[`SSR_STB_ESB] = esb_sum;
      stb[`SSR_STB_RQS] = rqs_r;
      srv = |(stb & sre_r & ~(8'h01 << `SSR_STB_RQS));
   end
   assign srv_rise = srv && !srv_d_r;

   // Request service rises on a new enabled summary; a set in the
   // same cycle as a clear wins so no request is lost.
   always_ff @(posedge clk) begin
      if (rst) begin
         rqs_r <= 1'b0;
         srv_d_r <= 1'b0;
         cause_r <= '0;
      end else begin
         srv_d_r <= srv;
         if (srv_rise) begin
            rqs_r <= 1'b1;
            cause_r <= {esb_sum & sre_r[`SSR_STB_ESB], mav & sre_r[`SSR_STB_MAV],
                        ques_sum & sre_r[`SSR_STB_QUES]};
         end else if (spoll || do_cls || (rd_esr && cause_r[2])
                      || (rd_qevt && cause_r[0])) begin
            rqs_r <= 1'b0;
         end
      end
   end

   // Serial poll answer, taken before its own clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         spoll_byte_r <= '0;
      end else if (spoll) begin
         spoll_byte_r <= stb;
      end
   end

   // ---------------------------------------------------------------
   // Event and enable registers.
   // ---------------------------------------------------------------
   // Standard events latch; read or clear-status empties.
   always_ff @(posedge clk) begin
      if (rst) begin
         esr_r <= 8'h00;
         esr_r[`SSR_ESR_PON] <= 1'b1;
      end else begin
         if (rd_esr || do_cls) begin
            esr_r <= 8'h00;
         end
         if (do_opc) begin
            esr_r[`SSR_ESR_OPC] <= 1'b1;
         end
         if (std_ev.qye) begin
            esr_r[`SSR_ESR_QYE] <= 1'b1;
         end
         if (std_ev.dde) begin
            esr_r[`SSR_ESR_DDE] <= 1'b1;
         end
         if (std_ev.exe) begin
            esr_r[`SSR_ESR_EXE] <= 1'b1;
         end
         if (std_ev.cme) begin
            esr_r[`SSR_ESR_CME] <= 1'b1;
         end
      end
   end

   // Questionable events latch; new sets beat the read clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         qevt_r <= '0;
      end else if (rd_qevt || do_cls) begin
         qevt_r <= ques_set;
      end else begin
         qevt_r <= qevt_r | ques_set;
      end
   end

   // Enable masks; power-up clears SRE and ESE only with the setting at 1, and the questionable mask always.
   always_ff @(posedge clk) begin
      if (rst) begin
         psc_r <= psc_saved;
         sre_r <= psc_saved ? 8'h00 : sre_saved;
         ese_r <= psc_saved ? 8'h00 : ese_saved;
         qena_r <= '0;
      end else if (wr_reg) begin
         if (addr == `SSR_OFS_SRE) begin
            sre_r <= wdata[7:0];
         end else if (addr == `SSR_OFS_ESE) begin
            ese_r <= wdata[7:0];
         end else if (addr == `SSR_OFS_QENA) begin
            qena_r <= wdata;
         end else if (addr == `SSR_OFS_PSC) begin
            psc_r <= wdata[0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Error queue.
   // ---------------------------------------------------------------
   // Once full, one overflow code replaces the newest entry and the
   // queue refuses errors until a read makes room.
   assign err_push = err_in.valid && !err_ovf_r;
   assign err_pop = rd_err && err_cnt_r != '0;

   always_ff @(posedge clk) begin
      if (rst || do_cls) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         err_cnt_r <= '0;
         err_ovf_r <= 1'b0;
      end else begin
         if (err_pop) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
            err_ovf_r <= 1'b0;
         end
         if (err_push && err_cnt_r == CW'(ERR_DEPTH) && !err_pop) begin
            err_ovf_r <= 1'b1;
         end else if (err_push && !err_pop) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
            err_cnt_r <= err_cnt_r + 1'b1;
         end else if (err_push) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end else if (err_pop) begin
            err_cnt_r <= err_cnt_r - 1'b1;
         end
      end
   end

   // Entry storage; the overflow write targets the newest slot.
   always_ff @(posedge clk) begin
      if (err_push && err_cnt_r == CW'(ERR_DEPTH) && !err_pop) begin
         err_mem[(wr_ptr_r == '0) ? PW'(ERR_DEPTH - 1) : wr_ptr_r - 1'b1]
            <= `SSR_ERR_OVF;
      end else if (err_push) begin
         err_mem[wr_ptr_r] <= err_in.code;
      end
   end

   // Panel indicator and one beep per generated error.
   always_ff @(posedge clk) begin
      if (rst) begin
         err_pending_r <= 1'b0;
         beep_r <= 1'b0;
      end else begin
         err_pending_r <= !do_cls && (err_cnt_r != '0 || err_push)
                          && !(err_pop && err_cnt_r == CW'(1) && !err_push);
         beep_r <= err_in.valid;
      end
   end

   // ---------------------------------------------------------------
   // Read data, valid only in the cycle after the strobe.
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst || !rd) begin
         rdata_r <= '0;
      end else if (addr == `SSR_OFS_STB) begin
         rdata_r <= {8'h00, stb};
      end else if (addr == `SSR_OFS_SRE) begin
         rdata_r <= {8'h00, sre_r};
      end else if (addr == `SSR_OFS_ESR) begin
         rdata_r <= {8'h00, esr_r};
      end else if (addr == `SSR_OFS_ESE) begin
         rdata_r <= {8'h00, ese_r};
      end else if (addr == `SSR_OFS_QCOND) begin
         rdata_r <= {14'h0, qcond};
      end else if (addr == `SSR_OFS_QEVT) begin
         rdata_r <= qevt_r;
      end else if (addr == `SSR_OFS_QENA) begin
         rdata_r <= qena_r;
      end else if (addr == `SSR_OFS_ERR) begin
         rdata_r <= (err_cnt_r == '0) ? `SSR_ERR_NONE : err_mem[rd_ptr_r];
      end else if (addr == `SSR_OFS_PSC) begin
         rdata_r <= {15'h0, psc_r};
      end else if (addr == `SSR_OFS_CMD) begin
         rdata_r <= {10'h0, halted_r, cmd_r};
      end else begin
         rdata_r <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_poll_req;
      spoll && rqs_r && !srv_rise;
   endsequence
   sequence s_poll_done;
      !rqs_r && spoll_byte_r[`SSR_STB_RQS];
   endsequence

   rqs_raise_a: assert property (srv_rise |=> rqs_r)
      else $error("request service not raised");
   poll_clear_a: assert property (s_poll_req |=> s_poll_done)
      else $error("serial poll answer or clear wrong");
   poll_keep_a: assert property (spoll |=> spoll_byte_r[5:3] == $past(stb[5:3]))
      else $error("serial poll changed other bits");
   stb_query_a: assert property (do_stbq && rqs_r && !spoll |=>
                                 rqs_r && resp_r.data == $past(stb))
      else $error("status query cleared request");
   cmd_hold_a: assert property (ops_pending |-> !exec)
      else $error("command ran during pending operation");
   opc_set_a: assert property (do_opc |=> esr_r[`SSR_ESR_OPC])
      else $error("completion bit not set");
   opcq_ans_a: assert property (do_opcq |=> resp_r.valid && resp_r.data == 8'h01)
      else $error("completion query answer wrong");
   err_ovf_a: assert property (err_push && err_cnt_r == CW'(ERR_DEPTH) && !err_pop
                               |=> err_ovf_r && err_cnt_r == CW'(ERR_DEPTH))
      else $error("queue overflow not handled");
   err_empty_a: assert property (rd_err && err_cnt_r == '0 |=> rdata_r == 16'h0000)
      else $error("empty queue read not zero");
   esr_clear_a: assert property (rd_esr && std_ev == '0 && !do_opc
                                 |=> esr_r == 8'h00 ##1 !stb[`SSR_STB_ESB])
      else $error("event read did not clear");
endmodule

// ==== ssr_status_unit_test.sv ====
`include "ssr_map.svh"
module ssr_status_unit_test
   import ssr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [1:0] qc;
      ssr_std_ev_t ev;
      logic [7:0] esr;
   } ssr_row_t;
   logic clk, rst, wr, rd, psc_saved, ops_pending, dev_clear, msg_push, msg_read;
   logic spoll, rqs_r, err_pending_r, beep_r, halted_r, host_en;
   logic [3:0] addr;
   logic [15:0] wdata, rdata_r, ques_set;
   logic [7:0] sre_saved, ese_saved, spoll_byte_r;
   logic [1:0] qcond;
   ssr_std_ev_t std_ev;
   ssr_err_t err_in;
   ssr_resp_t resp_r;
   int errors = 0, check_count = 0, cyc = 0, polls;
   ssr_row_t rows [4] = '{'{2'h0, 4'h8, 8'h04}, '{2'h1, 4'h4, 8'h08},
                          '{2'h2, 4'h2, 8'h10}, '{2'h3, 4'h1, 8'h20}};
   ssr_status_unit #(.ERR_DEPTH(20), .OUT_DEPTH(4)) dut (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .psc_saved(psc_saved),
      .sre_saved(sre_saved), .ese_saved(ese_saved), .ops_pending(ops_pending),
      .qcond(qcond), .ques_set(ques_set), .std_ev(std_ev), .err_in(err_in),
      .spoll(spoll), .dev_clear(dev_clear), .msg_push(msg_push), .msg_read(msg_read),
      .spoll_byte_r(spoll_byte_r), .rqs_r(rqs_r), .resp_r(resp_r),
      .err_pending_r(err_pending_r), .beep_r(beep_r), .halted_r(halted_r));
   ssr_bus_ctrl #(.LAT(3)) host (.clk(clk), .rst(rst), .en(host_en), .poll_cnt_r(polls),
      .rqs_r(rqs_r), .spoll(spoll));
   // ----------
   // Clock, timeout and helpers.
   // ----------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The whole sequence needs well under 5000 cycles; reaching 5000 means a hang.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(logic [3:0] a, logic [15:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rd_reg(string n, logic [3:0] a, logic [15:0] e);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(n, e, rdata_r);
   endtask
   task automatic pulse(int k);
      @(posedge clk) begin
         dev_clear <= (k == 0);
         msg_push <= (k == 1);
         msg_read <= (k == 2);
      end
      @(posedge clk) begin dev_clear <= 1'b0; msg_push <= 1'b0; msg_read <= 1'b0; end
   endtask
   task automatic wait_resp(logic [7:0] e);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         if (resp_r.valid === 1'b1) break;
      end
      chk("resp_valid", 16'h1, {15'h0, resp_r.valid});
      chk("resp_data", {8'h0, e}, {8'h0, resp_r.data});
   endtask
   task automatic reset_dut(logic psc);
      @(posedge clk) begin rst <= 1'b1; psc_saved <= psc; end
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   // ----------
   // Main sequence.
   // ----------
   initial begin
      {rst, wr, rd, dev_clear, msg_push, msg_read, ops_pending, host_en} = 8'hff;
      {wr, rd, dev_clear, msg_push, msg_read, ops_pending, host_en} = 7'h0;
      addr = 4'h0; wdata = 16'h0; qcond = 2'h0; ques_set = 16'h0; std_ev = '0; err_in = '0;
      psc_saved = 1'b0; sre_saved = 8'h20; ese_saved = 8'h01;
      reset_dut(1'b0);
      rd_reg("sre", `SSR_OFS_SRE, 16'h0020);
      rd_reg("ese", `SSR_OFS_ESE, 16'h0001);
      rd_reg("psc", `SSR_OFS_PSC, 16'h0000);
      reset_dut(1'b1);
      rd_reg("sre", `SSR_OFS_SRE, 16'h0000);
      rd_reg("psc", `SSR_OFS_PSC, 16'h0001);
      rd_reg("ese_clr", `SSR_OFS_ESE, 16'h0000);
      rd_reg("esr_pon", `SSR_OFS_ESR, 16'h0080);
      foreach (rows[i]) begin
         @(posedge clk) begin qcond <= rows[i].qc; std_ev <= rows[i].ev; end
         @(posedge clk) std_ev <= '0;
         rd_reg("qcond", `SSR_OFS_QCOND, {14'h0, rows[i].qc});
         rd_reg("esr_bit", `SSR_OFS_ESR, {8'h0, rows[i].esr});
      end
      // Completion raises a request that the host answers by poll.
      host_en <= 1'b1;
      wr_reg(`SSR_OFS_ESE, 16'h0001);
      wr_reg(`SSR_OFS_SRE, 16'h0020);
      wr_reg(`SSR_OFS_CMD, 16'h0002);
      for (int i = 0; i < 20 && polls == 0; i++) @(posedge clk);
      #1 chk("poll_byte", 16'h0060, {8'h0, spoll_byte_r});
      chk("rqs_after_poll", 16'h0, {15'h0, rqs_r});
      host_en <= 1'b0;
      rd_reg("stb", `SSR_OFS_STB, 16'h0020);
      // Status query waits behind running operations.
      ops_pending <= 1'b1;
      wr_reg(`SSR_OFS_CMD, 16'h0010);
      wr_reg(`SSR_OFS_CMD, 16'h0008);
      repeat (6) @(posedge clk) #1 chk("early_resp", 16'h0, {15'h0, resp_r.valid});
      ops_pending <= 1'b0;
      wait_resp(8'h20);
      pulse(2);
      rd_reg("esr_opc", `SSR_OFS_ESR, 16'h0001);
      rd_reg("stb_cleared", `SSR_OFS_STB, 16'h0000);
      wr_reg(`SSR_OFS_CMD, 16'h0004);
      wait_resp(`SSR_OPCQ_ANS);
      rd_reg("stb_mav", `SSR_OFS_STB, 16'h0010);
      pulse(2);
      rd_reg("stb_no_mav", `SSR_OFS_STB, 16'h0000);
      // Questionable summary request cleared by reading its event register.
      wr_reg(`SSR_OFS_QENA, 16'h0001);
      rd_reg("qena", `SSR_OFS_QENA, 16'h0001);
      wr_reg(`SSR_OFS_SRE, 16'h0008);
      @(posedge clk) ques_set <= 16'h0001;
      @(posedge clk) ques_set <= 16'h0;
      repeat (3) @(posedge clk);
      #1 chk("rqs_ques", 16'h1, {15'h0, rqs_r});
      // A status query while the request stands must keep it standing.
      wr_reg(`SSR_OFS_CMD, 16'h0008);
      wait_resp(8'h48);
      chk("rqs_stbq", 16'h1, {15'h0, rqs_r});
      pulse(2);
      rd_reg("stb_ques", `SSR_OFS_STB, 16'h0048);
      rd_reg("qevt", `SSR_OFS_QEVT, 16'h0001);
      chk("rqs_read", 16'h0, {15'h0, rqs_r});
      rd_reg("qevt_clr", `SSR_OFS_QEVT, 16'h0000);
      // Error queue: fill past depth, then drain.
      for (int i = 1; i <= 21; i++) begin
         @(posedge clk) err_in <= '{1'b1, 16'(i)};
         @(posedge clk) err_in.valid <= 1'b0;
         #1 chk("beep", 16'h1, {15'h0, beep_r});
      end
      chk("err_pending", 16'h1, {15'h0, err_pending_r});
      for (int i = 1; i <= 20; i++)
         rd_reg("err", `SSR_OFS_ERR, (i == 20) ? `SSR_ERR_OVF : 16'(i));
      rd_reg("err_empty", `SSR_OFS_ERR, `SSR_ERR_NONE);
      chk("err_pending", 16'h0, {15'h0, err_pending_r});
      chk("beep_off", 16'h0, {15'h0, beep_r});
      // Clear-status empties the queue and the questionable event register.
      @(posedge clk) begin err_in <= '{1'b1, 16'h0005}; ques_set <= 16'h0002; end
      @(posedge clk) begin err_in.valid <= 1'b0; ques_set <= 16'h0; end
      wr_reg(`SSR_OFS_CMD, 16'h0001);
      repeat (3) @(posedge clk);
      rd_reg("err_cls", `SSR_OFS_ERR, `SSR_ERR_NONE);
      rd_reg("qevt_cls", `SSR_OFS_QEVT, 16'h0000);
      chk("err_pend_cls", 16'h0, {15'h0, err_pending_r});
      // Output overload halts commands until device clear.
      pulse(0);
      repeat (5) pulse(1);
      #1 chk("halted", 16'h1, {15'h0, halted_r});
      wr_reg(`SSR_OFS_CMD, 16'h0004);
      repeat (5) @(posedge clk) #1 chk("halt_resp", 16'h0, {15'h0, resp_r.valid});
      pulse(0);
      #1 chk("unhalted", 16'h0, {15'h0, halted_r});
      wait_resp(`SSR_OPCQ_ANS);
      end_sim();
   end
endmodule
